/* File: pkg/esb_pkg.sv */
package esb_pkg;

    // ------------------------------------------------------------
    // register offsets (byte addresses, one word each)
    // ------------------------------------------------------------
    localparam logic [7:0]  ESB_OFF_AREA_WIDTH  = 8'h00;
    localparam logic [7:0]  ESB_OFF_AREA_STATES = 8'h04;
    localparam logic [7:0]  ESB_OFF_STALL_HIGH  = 8'h08;
    localparam logic [7:0]  ESB_OFF_STALL_LOW   = 8'h0C;
    localparam logic [7:0]  ESB_OFF_BUS_CTRL    = 8'h10;
    localparam logic [7:0]  ESB_OFF_STATUS      = 8'h14;

    // ------------------------------------------------------------
    // power-on reset values
    // ------------------------------------------------------------
    localparam logic [7:0]  ESB_RST_AREA_WIDTH  = 8'hFF;   // 1 = 8-bit space
    localparam logic [7:0]  ESB_RST_AREA_STATES = 8'hFF;   // 1 = 3-state space
    localparam logic [7:0]  ESB_RST_STALL_HIGH  = 8'hFF;   // 3 extension states
    localparam logic [7:0]  ESB_RST_STALL_LOW   = 8'hFF;   // 3 extension states
    localparam logic        ESB_RST_PIN_STALL   = 1'b0;    // pin stall disabled

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int          ESB_BIT_PIN_STALL   = 0;       // in bus control
    localparam int          ESB_BIT_BUSY        = 0;       // in status
    localparam int          ESB_BIT_STALL_LVL   = 1;       // in status
    localparam int          ESB_POS_AREA        = 4;       // in status, 3 bits
    localparam int          ESB_ADDR_AREA_LSB   = 21;      // area select bits

    // ------------------------------------------------------------
    // access sizes and bus states
    // ------------------------------------------------------------
    localparam logic [1:0]  ESB_SIZE_BYTE       = 2'h0;
    localparam logic [1:0]  ESB_SIZE_WORD       = 2'h1;
    localparam logic [1:0]  ESB_SIZE_LONG       = 2'h2;

    typedef enum logic [2:0] {
        ESB_IDLE,
        ESB_T1,
        ESB_T2,
        ESB_TW,
        ESB_T3
    } esb_state_t;

endpackage

/* File: verilog/esb_pin_sync.sv */
`timescale 1ns/1ns
module esb_pin_sync
    import esb_pkg::*;
(
    // clock and reset
    input  wire logic i_ref_clk,
    input  wire logic i_rst,
    // pin and filtered level
    input  wire logic i_pin,
    output logic      o_level
);

    logic s1_reg;
    logic s2_reg;
    logic s3_reg;
    logic level_reg;

    // three stages; level moves once the last two agree
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            s1_reg    <= 1'b1;
            s2_reg    <= 1'b1;
            s3_reg    <= 1'b1;
            level_reg <= 1'b1;
        end else begin
            s1_reg    <= i_pin;
            s2_reg    <= s1_reg;
            s3_reg    <= s2_reg;
            level_reg <= (s2_reg == s3_reg) ? s3_reg : level_reg;
        end
    end

    assign o_level = level_reg;

endmodule

/* File: verilog/esb_static_bus.sv */
`timescale 1ns/1ns
// Summary of operation
// - 16-bit space uses both halves; byte or word per cycle; longword as two words
// - 16-bit byte access: even address upper half, odd address lower half
// - one read strobe low for every read, whatever halves carry data
// - upper write strobe for upper half, lower for lower; 16-bit word write asserts both
// - byte write may drive undefined data on the unstrobed half
// - byte read leaves unused half as input and ignores it
// - 8-bit 2-state: lower write strobe high, no extension states
// - 8-bit 3-state: lower write strobe high, extension states allowed
// - 3-state spaces insert 0 to 3 programmed states per area after second state
// - with pin stall enabled, programmed states come before pin-requested ones
// - stall pin low at end of last second/extension state adds one more state
// - one pin stall enable bit covers every area
// - power-on: all areas 3-state, 3 programmed states, pin stall off
// - manual reset keeps all configuration registers
// - 8-bit space uses upper half, byte per cycle; word two, longword four
module esb_static_bus
    import esb_pkg::*;
(
    // clock and resets
    input  wire logic        i_ref_clk,
    input  wire logic        i_rst,
    input  wire logic        i_manual_rst,
    // register port
    input  wire logic [7:0]  i_reg_addr,
    input  wire logic [31:0] i_reg_wdata,
    input  wire logic        i_reg_wr,
    input  wire logic        i_reg_rd,
    output logic      [31:0] o_reg_rdata,
    // internal master request
    input  wire logic        i_req,
    input  wire logic        i_req_write,
    input  wire logic [1:0]  i_req_size,
    input  wire logic [23:0] i_req_addr,
    input  wire logic [31:0] i_req_wdata,
    output logic             o_req_ready,
    output logic             o_req_done,
    output logic      [31:0] o_req_rdata,
    // external bus
    output logic      [23:0] o_ext_addr,
    output logic             o_read_strobe_n,
    output logic             o_upper_write_strobe_n,
    output logic             o_lower_write_strobe_n,
    output logic      [15:0] o_data_out,
    output logic      [1:0]  o_data_oe,
    input  wire logic [15:0] i_data_in,
    input  wire logic        i_stall_n
);

    // ------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------
    logic [7:0]  area_width_reg;
    logic [7:0]  area_states_reg;
    logic [7:0]  stall_count_config_high_reg;
    logic [7:0]  stall_count_config_low_reg;
    logic        pin_stall_enable_reg;
    logic [31:0] rdata_reg;

    // ------------------------------------------------------------
    // transfer state
    // ------------------------------------------------------------
    esb_state_t  state_reg;
    esb_state_t  state_next;
    logic        wr_reg;
    logic [1:0]  size_reg;
    logic        wide_reg;
    logic        three_reg;
    logic [1:0]  prog_reg;
    logic [2:0]  area_reg;
    logic [23:0] addr_reg;
    logic [2:0]  beats_reg;
    logic [1:0]  cnt_reg;
    logic [1:0]  cnt_next;
    logic [31:0] wsh_reg;
    logic [31:0] rsh_reg;
    logic        ready_reg;
    logic        done_reg;
    logic [31:0] req_rdata_reg;
    logic        rd_n_reg;
    logic        uwr_n_reg;
    logic        lwr_n_reg;
    logic [15:0] dout_reg;
    logic [1:0]  doe_reg;

    // ------------------------------------------------------------
    // stall pin synchroniser
    // ------------------------------------------------------------
    logic        stall_level;

    esb_pin_sync u_stall_sync (
        .i_ref_clk (i_ref_clk),
        .i_rst     (i_rst),
        .i_pin     (i_stall_n),
        .o_level   (stall_level)
    );

    // ------------------------------------------------------------
    // register decode
    // ------------------------------------------------------------
    wire         sel_width  = (i_reg_addr == ESB_OFF_AREA_WIDTH);
    wire         sel_states = (i_reg_addr == ESB_OFF_AREA_STATES);
    wire         sel_high   = (i_reg_addr == ESB_OFF_STALL_HIGH);
    wire         sel_low    = (i_reg_addr == ESB_OFF_STALL_LOW);
    wire         sel_ctrl   = (i_reg_addr == ESB_OFF_BUS_CTRL);
    wire         sel_status = (i_reg_addr == ESB_OFF_STATUS);
    wire         busy       = (state_reg != ESB_IDLE);
    wire  [7:0]  status_val = {1'b0, area_reg, 2'h0, stall_level, busy};
    wire  [31:0] rd_mux     = sel_width  ? {24'h000000, area_width_reg} :
                              sel_states ? {24'h000000, area_states_reg} :
                              sel_high   ? {24'h000000, stall_count_config_high_reg} :
                              sel_low    ? {24'h000000, stall_count_config_low_reg} :
                              sel_ctrl   ? {31'h00000000, pin_stall_enable_reg} :
                              sel_status ? {24'h000000, status_val} :
                                           32'h00000000;

    // configuration writes; only power-on reset touches them
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            area_width_reg              <= ESB_RST_AREA_WIDTH;
            area_states_reg             <= ESB_RST_AREA_STATES;
            stall_count_config_high_reg <= ESB_RST_STALL_HIGH;
            stall_count_config_low_reg  <= ESB_RST_STALL_LOW;
            pin_stall_enable_reg        <= ESB_RST_PIN_STALL;
        end else if (i_reg_wr) begin
            // manual reset is not looked at here
            if (sel_width)  area_width_reg              <= i_reg_wdata[7:0];
            if (sel_states) area_states_reg             <= i_reg_wdata[7:0];
            if (sel_high)   stall_count_config_high_reg <= i_reg_wdata[7:0];
            if (sel_low)    stall_count_config_low_reg  <= i_reg_wdata[7:0];
            if (sel_ctrl)   pin_stall_enable_reg        <= i_reg_wdata[ESB_BIT_PIN_STALL];
        end
    end

    // read data, valid the cycle after the strobe
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            rdata_reg <= 32'h00000000;
        end else begin
            rdata_reg <= i_reg_rd ? rd_mux : 32'h00000000;
        end
    end

    // ------------------------------------------------------------
    // request decode at load time
    // ------------------------------------------------------------
    wire         load       = (state_reg == ESB_IDLE) && i_req;
    wire  [2:0]  req_area   = i_req_addr[ESB_ADDR_AREA_LSB +: 3];
    wire  [15:0] stall_cfg  = {stall_count_config_high_reg, stall_count_config_low_reg};
    wire  [1:0]  req_prog   = stall_cfg[{req_area, 1'b0} +: 2];
    wire         req_wide   = !area_width_reg[req_area];
    wire  [31:0] req_wsh    = (i_req_size == ESB_SIZE_BYTE) ? {i_req_wdata[7:0], 24'h000000} :
                              (i_req_size == ESB_SIZE_WORD) ? {i_req_wdata[15:0], 16'h0000} :
                                                              i_req_wdata;
    // 16-bit: byte 1, word 1, long 2; 8-bit: byte 1, word 2, long 4
    wire  [2:0]  req_beats  = (i_req_size == ESB_SIZE_BYTE) ? 3'h1 :
                              req_wide ? ((i_req_size == ESB_SIZE_WORD) ? 3'h1 : 3'h2) :
                              ((i_req_size == ESB_SIZE_WORD) ? 3'h2 : 3'h4);

    // ------------------------------------------------------------
    // beat decode
    // ------------------------------------------------------------
    wire         word_beat  = wide_reg && (size_reg != ESB_SIZE_BYTE);
    wire  [23:0] addr_step  = word_beat ? 24'h000002 : 24'h000001;
    wire  [7:0]  byte_in    = (wide_reg && addr_reg[0]) ? i_data_in[7:0] :
                                                          i_data_in[15:8];
    wire  [31:0] rsh_next   = word_beat ? {rsh_reg[15:0], i_data_in} :
                                          {rsh_reg[23:0], byte_in};
    wire         last_data  = three_reg ? (state_reg == ESB_T3) :
                                          (state_reg == ESB_T2);
    wire         more_beats = (beats_reg != 3'h1);
    wire         stall_req  = pin_stall_enable_reg && !stall_level;

    // ------------------------------------------------------------
    // bus state sequencing
    // ------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        unique case (state_reg)
            ESB_IDLE: begin
                if (i_req) state_next = ESB_T1;
            end
            ESB_T1: begin
                state_next = ESB_T2;
            end
            ESB_T2: begin
                if (!three_reg) begin
                    state_next = more_beats ? ESB_T1 : ESB_IDLE;
                end else if (prog_reg != 2'h0) begin
                    state_next = ESB_TW;
                    cnt_next   = prog_reg;
                end else if (stall_req) begin
                    state_next = ESB_TW;
                    cnt_next   = 2'h0;
                end else begin
                    state_next = ESB_T3;
                end
            end
            ESB_TW: begin
                if (cnt_reg > 2'h1) begin
                    cnt_next = cnt_reg - 2'h1;
                end else if (stall_req) begin
                    cnt_next = 2'h0;
                end else begin
                    state_next = ESB_T3;
                end
            end
            ESB_T3: begin
                state_next = more_beats ? ESB_T1 : ESB_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // next-cycle pin values
    // ------------------------------------------------------------
    wire         beat_adv   = last_data && more_beats;
    wire         nx_wr      = load ? i_req_write : wr_reg;
    wire         nx_wide    = load ? req_wide : wide_reg;
    wire  [1:0]  nx_size    = load ? i_req_size : size_reg;
    wire  [23:0] nx_addr    = load ? i_req_addr :
                              beat_adv ? (addr_reg + addr_step) : addr_reg;
    wire  [31:0] nx_wsh     = load ? req_wsh :
                              beat_adv ? (word_beat ? {wsh_reg[15:0], 16'h0000} :
                                                      {wsh_reg[23:0], 8'h00}) : wsh_reg;
    wire         nx_word    = nx_wide && (nx_size != ESB_SIZE_BYTE);
    wire         nx_upper   = nx_word || !nx_wide || !nx_addr[0];
    wire         nx_lower   = nx_wide && (nx_word || nx_addr[0]);
    wire         nx_cycle   = (state_next != ESB_IDLE);
    wire         nx_wstrobe = (state_next == ESB_T2) || (state_next == ESB_TW);
    // byte access copies the byte onto both halves; the unstrobed half is don't-care
    wire  [15:0] nx_dout    = nx_word ? nx_wsh[31:16] : {nx_wsh[31:24], nx_wsh[31:24]};
    wire  [1:0]  nx_doe     = (nx_cycle && nx_wr) ? {1'b1, nx_wide} : 2'h0;

    // ------------------------------------------------------------
    // transfer registers
    // ------------------------------------------------------------
    always_ff @(posedge i_ref_clk) begin
        if (i_rst || i_manual_rst) begin
            state_reg <= ESB_IDLE;
            cnt_reg   <= 2'h0;
            beats_reg <= 3'h1;
            rsh_reg   <= 32'h00000000;
        end else begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
            if (load) begin
                beats_reg <= req_beats;
                rsh_reg   <= 32'h00000000;
            end else if (last_data) begin
                beats_reg <= beats_reg - 3'h1;
                rsh_reg   <= rsh_next;
            end
        end
    end

    // request attributes held for the whole transfer
    always_ff @(posedge i_ref_clk) begin
        if (i_rst || i_manual_rst) begin
            wr_reg    <= 1'b0;
            size_reg  <= ESB_SIZE_BYTE;
            wide_reg  <= 1'b0;
            three_reg <= 1'b1;
            prog_reg  <= 2'h0;
            area_reg  <= 3'h0;
        end else if (load) begin
            wr_reg    <= i_req_write;
            size_reg  <= i_req_size;
            wide_reg  <= req_wide;
            three_reg <= area_states_reg[req_area];
            prog_reg  <= req_prog;
            area_reg  <= req_area;
        end
    end

    // completion toward the internal master
    always_ff @(posedge i_ref_clk) begin
        if (i_rst || i_manual_rst) begin
            ready_reg     <= 1'b0;
            done_reg      <= 1'b0;
            req_rdata_reg <= 32'h00000000;
        end else begin
            ready_reg <= (state_next == ESB_IDLE);
            done_reg  <= last_data && !more_beats;
            if (last_data && !more_beats && !wr_reg) req_rdata_reg <= rsh_next;
        end
    end

    // external pins, registered from next-cycle values
    always_ff @(posedge i_ref_clk) begin
        if (i_rst || i_manual_rst) begin
            addr_reg  <= 24'h000000;
            wsh_reg   <= 32'h00000000;
            rd_n_reg  <= 1'b1;
            uwr_n_reg <= 1'b1;
            lwr_n_reg <= 1'b1;
            dout_reg  <= 16'h0000;
            doe_reg   <= 2'h0;
        end else begin
            addr_reg  <= nx_addr;
            wsh_reg   <= nx_wsh;
            rd_n_reg  <= !(nx_cycle && !nx_wr);
            uwr_n_reg <= !(nx_wstrobe && nx_wr && nx_upper);
            lwr_n_reg <= !(nx_wstrobe && nx_wr && nx_lower);
            dout_reg  <= nx_dout;
            doe_reg   <= nx_doe;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign o_reg_rdata            = rdata_reg;
    assign o_req_ready            = ready_reg;
    assign o_req_done             = done_reg;
    assign o_req_rdata            = req_rdata_reg;
    assign o_ext_addr             = addr_reg;
    assign o_read_strobe_n        = rd_n_reg;
    assign o_upper_write_strobe_n = uwr_n_reg;
    assign o_lower_write_strobe_n = lwr_n_reg;
    assign o_data_out             = dout_reg;
    assign o_data_oe              = doe_reg;

endmodule

/* File: dv/esb_static_bus_props.sv */
`timescale 1ns/1ns
module esb_static_bus_props
    import esb_pkg::*;
(
    // clock and resets
    input wire logic        i_ref_clk,
    input wire logic        i_rst,
    input wire logic        i_manual_rst,
    // register and request side
    input wire logic        i_reg_rd,
    input wire logic [31:0] o_reg_rdata,
    input wire logic        i_req,
    input wire logic        o_req_ready,
    input wire logic        o_req_done,
    // external bus
    input wire logic        o_read_strobe_n,
    input wire logic        o_upper_write_strobe_n,
    input wire logic        o_lower_write_strobe_n,
    input wire logic [15:0] o_data_out,
    input wire logic [1:0]  o_data_oe
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_rst || i_manual_rst);

    a_read_no_drive: assert property (!o_read_strobe_n |-> o_data_oe == 2'h0 &&
        o_upper_write_strobe_n && o_lower_write_strobe_n) else $error("drive during read");
    a_lower_needs_wide: assert property (!o_lower_write_strobe_n |-> o_data_oe == 2'h3)
        else $error("lower strobe outside wide write");
    a_upper_drives: assert property (!o_upper_write_strobe_n |-> o_data_oe[1])
        else $error("upper strobe without upper drive");
    a_write_data_hold: assert property (!o_upper_write_strobe_n &&
        $past(!o_upper_write_strobe_n) |-> $stable(o_data_out)) else $error("data moved");
    a_strobe_after_t1: assert property ($rose(o_data_oe[1]) |->
        o_upper_write_strobe_n && o_lower_write_strobe_n) else $error("strobe in first state");
    a_take_min_two: assert property (i_req && o_req_ready |=>
        (!o_req_ready && !o_req_done) [*2]) else $error("cycle shorter than two states");
    a_done_pulse: assert property (o_req_done |-> o_req_ready ##1 !o_req_done)
        else $error("done not a single pulse");
    a_idle_quiet: assert property (o_req_ready |-> o_read_strobe_n &&
        o_upper_write_strobe_n && o_data_oe == 2'h0) else $error("bus active while idle");
    a_rdata_idle: assert property (!$past(i_reg_rd) |-> o_reg_rdata == 32'h0)
        else $error("read data outside its cycle");
endmodule

bind esb_static_bus esb_static_bus_props u_esb_static_bus_props (.*);

/* File: dv/esb_mem_model.sv */
`timescale 1ns/1ns
module esb_mem_model (
    // clock and bench control
    input  wire logic        i_ref_clk,
    input  wire logic        i_wide,
    input  wire logic        i_stall_go,
    input  wire logic [3:0]  i_stall_len,
    // external bus
    input  wire logic [23:0] i_addr,
    input  wire logic        i_read_strobe_n,
    input  wire logic        i_upper_write_strobe_n,
    input  wire logic        i_lower_write_strobe_n,
    input  wire logic [15:0] i_data,
    output logic      [15:0] o_data,
    output logic             o_stall_n
);
    logic [7:0]  mem [256];
    logic [15:0] last_reg;
    logic [3:0]  stall_cnt_reg;
    wire  [7:0]  up_idx = i_wide ? {i_addr[7:1], 1'b0} : i_addr[7:0];
    wire  [7:0]  lo_idx = {i_addr[7:1], 1'b1};

    // memory cleared, matches bench reference
    initial begin
        foreach (mem[i]) mem[i] = 8'h0;
        last_reg = 16'h0;
        stall_cnt_reg = 4'h0;
    end
    // byte lanes written by their own strobe, undriven half ignored
    always @(posedge i_ref_clk) begin
        if (!i_upper_write_strobe_n) mem[up_idx] <= i_data[15:8];
        if (!i_lower_write_strobe_n) mem[lo_idx] <= i_data[7:0];
        last_reg <= o_data;
        stall_cnt_reg <= i_stall_go ? i_stall_len : stall_cnt_reg - {3'h0, stall_cnt_reg != 0};
    end
    // read data only while selected, changing pattern otherwise
    assign o_data = !i_read_strobe_n ? {mem[up_idx], i_wide ? mem[lo_idx] : ~last_reg[7:0]}
                                     : ~last_reg;
    assign o_stall_n = (stall_cnt_reg == 4'h0);
endmodule

/* File: dv/esb_static_bus_test.sv */
`timescale 1ns/1ns
module esb_static_bus_test;
    import esb_pkg::*;
    logic        clk, rst, mrst, reg_wr, reg_rd, req, req_write, wide, stall_go;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata, req_wdata, seed, rd_val, wd, exp_val;
    logic [1:0]  req_size;
    logic [23:0] req_addr;
    logic [3:0]  stall_len;
    wire  [31:0] reg_rdata, req_rdata;
    wire         ready, done, rd_n, uwr_n, lwr_n, stall_n;
    wire  [23:0] ext_addr;
    wire  [15:0] dout, din;
    wire  [1:0]  oe;
    logic [7:0]  cfg [5];
    logic [7:0]  ref_mem [256];
    int          fail_count, total_checks, n, beats, slen, nb, base;

    esb_static_bus u_esb_static_bus (.i_ref_clk(clk), .i_rst(rst), .i_manual_rst(mrst),
        .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd),
        .o_reg_rdata(reg_rdata), .i_req(req), .i_req_write(req_write), .i_req_size(req_size),
        .i_req_addr(req_addr), .i_req_wdata(req_wdata), .o_req_ready(ready), .o_req_done(done),
        .o_req_rdata(req_rdata), .o_ext_addr(ext_addr), .o_read_strobe_n(rd_n),
        .o_upper_write_strobe_n(uwr_n), .o_lower_write_strobe_n(lwr_n), .o_data_out(dout),
        .o_data_oe(oe), .i_data_in(din), .i_stall_n(stall_n));
    esb_mem_model u_esb_mem_model (.i_ref_clk(clk), .i_wide(wide), .i_stall_go(stall_go),
        .i_stall_len(stall_len), .i_addr(ext_addr), .i_read_strobe_n(rd_n),
        .i_upper_write_strobe_n(uwr_n), .i_lower_write_strobe_n(lwr_n), .i_data(dout),
        .o_data(din), .o_stall_n(stall_n));

    // ----------------------------------------
    // clock, helpers and bus tasks
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h0);
    endfunction
    task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic check_span(input int got, input int lo, input int hi);
        total_checks++;
        if (got < lo || got > hi) begin
            fail_count++;
            $display("mismatch at %0t: %0d cycles not in %0d..%0d", $time, got, lo, hi);
        end
    endtask
    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= {24'h0, d};
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic reg_read(input logic [7:0] a);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 rd_val = reg_rdata;
    endtask
    task automatic xfer(input logic w, input logic [1:0] sz, input logic [23:0] a,
                        input logic go);
        int k;
        k = 0;
        #1;
        while (ready !== 1'b1 && k < 400) begin
            @(posedge clk);
            #1 k++;
        end
        @(posedge clk);
        req <= 1'b1;
        req_write <= w;
        req_size <= sz;
        req_addr <= a;
        req_wdata <= wd;
        @(posedge clk);
        req <= 1'b0;
        stall_go <= go;
        n = 0;
        do begin
            @(posedge clk);
            stall_go <= 1'b0;
            #1 n++;
        end while (done !== 1'b1 && n < 400);
        rd_val = req_rdata;
    endtask
    // write config, keep bench copy
    task automatic set_cfg(input int i, input logic [7:0] v);
        cfg[i] = v;
        reg_write(8'(i * 4), v);
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    // ----------------------------------------
    // watchdog
    // ----------------------------------------
    initial begin
        #100000;
        fail_count++;
        results;
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        {rst, mrst, reg_wr, reg_rd, req, req_write, stall_go} = 7'h40;
        {reg_addr, reg_wdata, req_size, req_addr, req_wdata} = '0;
        {stall_len, wide, wd} = '0;
        fail_count = 0;
        total_checks = 0;
        seed = 32'h8D6537D0;
        foreach (ref_mem[i]) ref_mem[i] = 8'h0;
        cfg = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h00};
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 6; i++) begin
            reg_read(8'(i * 4));
            if (i < 5) check_val(rd_val, {24'h0, cfg[i]});
        end
        reg_read(8'h18);
        check_val(rd_val, 32'h0);
        for (int it = 0; it < 48; it++) begin
            seed = lfsr(seed);
            if (it % 8 == 7) for (int i = 0; i < 5; i++) begin
                seed = lfsr(seed);
                set_cfg(i, i == 4 ? {7'h0, seed[9]} : seed[7:0]);
            end
            req_size = 2'(seed[5:4] % 3);
            req_addr = {seed[2:0], 13'h0, seed[15:8]};
            wide = !cfg[0][req_addr[23:21]];
            if (wide && req_size != 2'h0) req_addr[0] = 1'b0;
            nb = 1 << req_size;
            beats = wide ? (req_size == 2'h2 ? 2 : 1) : nb;
            slen = cfg[2 + (req_addr[23] ? 0 : 1)] >> (2 * req_addr[22:21]);
            base = beats * (cfg[1][req_addr[23:21]] ? 3 + (slen & 3) : 2);
            stall_len = seed[19:16];
            seed = lfsr(seed);
            wd = seed & ((64'h1 << (8 * nb)) - 1);
            for (int b = 0; b < nb; b++) ref_mem[8'(req_addr + b)] = 8'(wd >> (8 * (nb - 1 - b)));
            for (int w = 1; w >= 0; w--) begin
                // let an earlier stall clear the pin and its synchroniser
                while (stall_n !== 1'b1) @(posedge clk);
                repeat (5) @(posedge clk);
                xfer(w[0], req_size, req_addr, it[0]);
                if (it[0] && cfg[4][0] && cfg[1][req_addr[23:21]])
                    check_span(n, base, base + beats * 20);
                else check_span(n, base, base);
            end
            exp_val = 32'h0;
            for (int b = 0; b < nb; b++) exp_val = {exp_val[23:0], ref_mem[8'(req_addr + b)]};
            check_val(rd_val & ((64'h1 << (8 * nb)) - 1), exp_val);
        end
        // stall pin held low across a short 3-state read
        set_cfg(0, 8'h00);
        set_cfg(1, 8'hFF);
        set_cfg(3, 8'h00);
        set_cfg(4, 8'h01);
        wide = 1'b1;
        @(posedge clk);
        stall_len <= 4'hF;
        stall_go <= 1'b1;
        repeat (5) @(posedge clk); // low level through the synchroniser first
        xfer(1'b0, 2'h1, 24'h000010, 1'b0);
        check_span(n, 4, 30);
        // manual reset keeps configuration
        @(posedge clk);
        mrst <= 1'b1;
        repeat (2) @(posedge clk);
        mrst <= 1'b0;
        for (int i = 0; i < 5; i++) begin
            reg_read(8'(i * 4));
            check_val(rd_val, {24'h0, cfg[i]});
        end
        xfer(1'b0, 2'h1, 24'h000010, 1'b0);
        check_span(n, 3, 3);
        results;
    end
endmodule
